// >>> src/fbc_pkg.sv
// shared constants and types of the flash bank command interface
package fbc_pkg;
	// ------------------------------------------------------------
	// geometry and timing
	// ------------------------------------------------------------
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int BANK_LSB = 19;
	localparam int BLK_LSB = 16;
	localparam int BANK_W = ADDR_W - BANK_LSB;
	localparam int BLK_W = ADDR_W - BLK_LSB;
	localparam int NUM_BANKS = 1 << BANK_W;
	localparam int NUM_BLOCKS = 1 << BLK_W;
	localparam int BUF_WORDS = 32;
	localparam int BUF_IDX_W = 5;
	localparam int CLK_PERIOD_NS = 5;
	localparam int PROG_TIME_NS = 10000;
	localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC_DEF = 200000;
	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_SIG = 8'h90;
	localparam logic [7:0] CMD_CFI = 8'h98;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT = 8'h10;
	localparam logic [7:0] CMD_BUF = 8'hE8;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	// ------------------------------------------------------------
	// status bits and signature offsets
	// ------------------------------------------------------------
	localparam int SR_READY = 7;
	localparam int SR_ERS = 5;
	localparam int SR_PRG = 4;
	localparam int SR_LOW = 1;
	localparam logic [2:0] SIG_MAKER = 3'h0;
	localparam logic [2:0] SIG_DEVICE = 3'h1;
	localparam logic [2:0] SIG_LOCK = 3'h2;
	localparam logic [2:0] SIG_CONFIG = 3'h5;
	typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_SIG, MODE_CFI} fbc_mode_t;
	typedef enum logic [1:0] {OP_WORD, OP_BUF, OP_ERASE} fbc_op_t;
endpackage

// >>> src/fbc_op_if.sv
// link between command decoder and program/erase engine
`timescale 1ns/100ps
`default_nettype none
interface fbc_op_if;
	import fbc_pkg::*;
	logic start;
	fbc_op_t op;
	logic locked;
	logic [ADDR_W-1:0] base;
	logic [BUF_IDX_W-1:0] last;
	logic load;
	logic [BUF_IDX_W-1:0] load_idx;
	logic [DATA_W-1:0] load_data;
	logic abort;
	logic busy;
	logic done;
	logic fail;
	modport ctrl(output start, op, locked, base, last, load, load_idx, load_data, abort,
		input busy, done, fail);
	modport eng(input start, op, locked, base, last, load, load_idx, load_data, abort,
		output busy, done, fail);
endinterface
`default_nettype wire

// >>> src/fbc_bus_sync.sv
// pin synchroniser and bus write / read edge detection
`timescale 1ns/100ps
`default_nettype none
module fbc_bus_sync
	import fbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [4:0] ctl_pin,
	input wire logic [ADDR_W-1:0] addr_pin,
	input wire logic [DATA_W-1:0] dq_pin,
	output logic wr_evt,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [DATA_W-1:0] wr_data,
	output logic rd_evt,
	output logic rd_on,
	output logic [ADDR_W-1:0] rd_addr,
	output logic hold
);
	// ctl_pin = {lockout, reset pin low-active, oe_n, we_n, ce_n}
	logic [4+ADDR_W+DATA_W:0] s1_reg;
	logic [4+ADDR_W+DATA_W:0] s2_reg;
	logic wr_act;
	logic wr_act_reg;
	logic rd_on_reg;
	// ------------------------------------------------------------
	// two-flop synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		s1_reg <= {ctl_pin, addr_pin, dq_pin};
		s2_reg <= s1_reg;
	end
	assign wr_act = !s2_reg[DATA_W+ADDR_W] && !s2_reg[DATA_W+ADDR_W+1]
		&& s2_reg[DATA_W+ADDR_W+2];
	assign rd_on = !s2_reg[DATA_W+ADDR_W] && !s2_reg[DATA_W+ADDR_W+2];
	assign hold = !s2_reg[DATA_W+ADDR_W+3] || s2_reg[DATA_W+ADDR_W+4];
	assign rd_addr = s2_reg[DATA_W +: ADDR_W];
	// write ends on whichever of ce_n or we_n rises first
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			wr_act_reg <= 1'b0;
			rd_on_reg <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			wr_act_reg <= wr_act;
			rd_on_reg <= rd_on;
			if (wr_act) begin
				wr_addr <= s2_reg[DATA_W +: ADDR_W];
				wr_data <= s2_reg[DATA_W-1:0];
			end
		end
	end
	assign wr_evt = wr_act_reg && !wr_act;
	// read starts on falling ce_n or oe_n
	assign rd_evt = rd_on && !rd_on_reg;
endmodule
`default_nettype wire

// >>> src/fbc_prog_engine.sv
// program/erase engine with write buffer
`timescale 1ns/100ps
`default_nettype none
module fbc_prog_engine
	import fbc_pkg::*;
#(
	parameter int PROG_CYC_P = PROG_CYC,
	parameter int ERASE_CYC_P = ERASE_CYC_DEF,
	parameter int DEPTH = BUF_WORDS
) (
	input wire logic core_clk,
	input wire logic resetn,
	fbc_op_if.eng op_if,
	output logic arr_we,
	output logic arr_erase,
	output logic [ADDR_W-1:0] arr_addr,
	output logic [DATA_W-1:0] arr_wdata
);
	typedef enum logic [3:0] {E_IDLE = 4'b0001, E_WAIT = 4'b0010, E_WRITE = 4'b0100,
		E_DONE = 4'b1000} fbc_eng_t;
	fbc_eng_t st_reg;
	fbc_op_t op_reg;
	logic [DATA_W-1:0] buf_mem [DEPTH];
	logic [ADDR_W-1:0] base_reg;
	logic [BUF_IDX_W-1:0] idx_reg;
	logic [BUF_IDX_W-1:0] last_reg;
	logic [31:0] timer_reg;
	logic fail_reg;
	// refuse sizes that the index and timer logic cannot serve
	if (DEPTH != (1 << BUF_IDX_W) || PROG_CYC_P < 1 || ERASE_CYC_P < 1) begin : g_bad_param
		$error("engine parameters out of range");
	end
	// cycles per step; an unaligned buffer start doubles programming time
	function automatic logic [31:0] step_cyc(input fbc_op_t op, input logic [ADDR_W-1:0] a);
		step_cyc = (op == OP_ERASE) ? 32'(ERASE_CYC_P) : 32'(PROG_CYC_P);
		if (op == OP_BUF && a[BUF_IDX_W-1:0] != '0)
			step_cyc = 32'(2 * PROG_CYC_P); // R22
	endfunction
	// ------------------------------------------------------------
	// buffer load
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (op_if.load)
			buf_mem[op_if.load_idx] <= op_if.load_data;
	end
	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		arr_we <= 1'b0;
		arr_erase <= 1'b0;
		if (!resetn || op_if.abort) begin
			st_reg <= E_IDLE; // R17
			op_reg <= OP_WORD;
			base_reg <= '0;
			idx_reg <= '0;
			last_reg <= '0;
			timer_reg <= '0;
			fail_reg <= 1'b0;
			arr_addr <= '0;
			arr_wdata <= '0;
		end else begin
			unique case (st_reg)
				E_IDLE: if (op_if.start) begin
					op_reg <= op_if.op;
					base_reg <= op_if.base;
					last_reg <= op_if.last;
					idx_reg <= '0;
					fail_reg <= op_if.locked; // R13
					timer_reg <= step_cyc(op_if.op, op_if.base);
					st_reg <= op_if.locked ? E_DONE : E_WAIT;
				end
				E_WAIT: begin
					timer_reg <= timer_reg - 32'd1;
					if (timer_reg <= 32'd1)
						st_reg <= E_WRITE;
				end
				E_WRITE: begin
					arr_addr <= base_reg + ADDR_W'(idx_reg);
					arr_wdata <= buf_mem[idx_reg];
					arr_erase <= (op_reg == OP_ERASE); // R12
					arr_we <= (op_reg != OP_ERASE);
					if (op_reg == OP_BUF && idx_reg != last_reg) begin
						idx_reg <= idx_reg + 1'b1;
						timer_reg <= step_cyc(op_reg, base_reg);
						st_reg <= E_WAIT;
					end else
						st_reg <= E_DONE;
				end
				E_DONE: st_reg <= E_IDLE;
			endcase
		end
	end
	assign op_if.busy = (st_reg != E_IDLE);
	assign op_if.done = (st_reg == E_DONE);
	assign op_if.fail = fail_reg;
endmodule
`default_nettype wire

// >>> src/fbc_cmd_if.sv
// command interpreter of a multi-bank flash: read modes, sequences, error flags
// Behaviour
// [R1] read-array to busy bank sets array mode, operation continues
// [R2] read-status sets bank to status mode until read-array
// [R3] read data latched on falling chip or output enable
// [R4] status, signature, query change only addressed bank, accepted any time
// [R5] host reads status-like data only with single reads
// [R6] signature mode returns maker, part, lock, protection or configuration
// [R7] signature command refused during protection register programming
// [R8] signature or query to busy bank enters mode, engine continues
// [R9] query command makes bank return query data until read-array
// [R10] clear-status zeroes all error flags, read mode unchanged
// [R11] error flags sticky until cleared
// [R12] erase is setup then confirm with block address; block set to ones
// [R13] protected block aborts operation and reports error
// [R14] bad erase confirm sets program and erase fail, abandons
// [R15] issued erase puts bank in status mode
// [R16] busy bank accepts only read modes and suspend; no suspend command here, busy bank accepts read modes only
// [R17] reset pin low aborts erase or program
// [R18] word program is setup then address/data write; bank reads status
// [R19] buffer setup shows status; ready bit tells whether buffer free
// [R20] second buffer write gives count n; n+1 words expected
// [R21] n+1 words in start..start+n within block, then confirm
// [R22] unaligned buffer start doubles programming time
// [R23] one confirm code completes erase or buffer program
// [R24] reset, power-up and lockout restore array mode; bad commands ignored
// [R25] buffer program refused while both fail flags set
// [R26] bad buffer address or sequence sets error, array untouched
// [R27] per-bank read mode, single command sequence for the busy bank
// [R28] other writes to busy bank change neither flags nor mode
`timescale 1ns/100ps
`default_nettype none
module fbc_cmd_if
	import fbc_pkg::*;
#(
	parameter int ERASE_CYC = ERASE_CYC_DEF,
	parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
	parameter logic [15:0] PART_ID = 16'h5A01 // arbitrary value
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic active_low_reset_pin,
	input wire logic lockout_pin,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [NUM_BLOCKS-1:0] lock_bits,
	input wire logic prot_prog_busy,
	input wire logic [DATA_W-1:0] arr_rdata,
	input wire logic [DATA_W-1:0] cfi_word,
	input wire logic [DATA_W-1:0] cfg_word,
	input wire logic [DATA_W-1:0] prot_word,
	output logic arr_we,
	output logic arr_erase,
	output logic [ADDR_W-1:0] arr_addr,
	output logic [DATA_W-1:0] arr_wdata,
	output logic ctrl_busy
);
	typedef enum logic [5:0] {C_IDLE = 6'b000001, C_ERS = 6'b000010, C_PRG = 6'b000100,
		C_BSET = 6'b001000, C_BLOAD = 6'b010000, C_BCONF = 6'b100000} fbc_cmd_t;
	fbc_op_if op_if ();
	fbc_cmd_t st_reg;
	fbc_cmd_t st_next;
	fbc_mode_t mode_reg [NUM_BANKS];
	fbc_op_t run_op_reg;
	logic [BANK_W-1:0] busy_bank_reg;
	logic [BLK_W-1:0] blk_reg;
	logic [BUF_IDX_W-1:0] cnt_reg;
	logic [BUF_IDX_W-1:0] left_reg;
	logic [ADDR_W-1:0] start_reg;
	logic first_reg;
	logic prg_fail_reg;
	logic ers_fail_reg;
	logic low_err_reg;
	logic wr_evt;
	logic rd_evt;
	logic rd_on;
	logic hold;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0] cmd;
	logic [BANK_W-1:0] wbank;
	logic busy_any;
	logic bank_busy;
	logic [7:0] status;
	logic set_mode;
	fbc_mode_t new_mode;
	logic set_prg;
	logic set_ers;
	logic clr_flags;
	logic go;
	fbc_op_t go_op;
	logic ld;
	logic [ADDR_W-1:0] off;

	function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:BANK_LSB];
	endfunction
	function automatic logic [BLK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:BLK_LSB];
	endfunction
	// ------------------------------------------------------------
	// pins and engine
	// ------------------------------------------------------------
	fbc_bus_sync u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.ctl_pin({lockout_pin, active_low_reset_pin, oe_n, we_n, ce_n}),
		.addr_pin(addr),
		.dq_pin(dq_in),
		.wr_evt(wr_evt),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_evt(rd_evt),
		.rd_on(rd_on),
		.rd_addr(rd_addr),
		.hold(hold)
	);
	fbc_prog_engine #(
		.ERASE_CYC_P(ERASE_CYC)
	) u_eng (
		.core_clk(core_clk),
		.resetn(resetn),
		.op_if(op_if.eng),
		.arr_we(arr_we),
		.arr_erase(arr_erase),
		.arr_addr(arr_addr),
		.arr_wdata(arr_wdata)
	);
	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	assign cmd = wr_data[7:0];
	assign wbank = bank_of(wr_addr);
	assign busy_any = op_if.busy || op_if.start;
	assign bank_busy = busy_any && (wbank == busy_bank_reg);
	assign off = wr_addr - (first_reg ? wr_addr : start_reg);
	assign status = {!busy_any, 1'b0, ers_fail_reg, prg_fail_reg, 2'h0, low_err_reg,
		1'b0};
	// next sequence state and the side effects of one bus write
	always_comb begin
		st_next = st_reg;
		set_mode = 1'b0;
		new_mode = MODE_ARRAY;
		set_prg = 1'b0;
		set_ers = 1'b0;
		clr_flags = 1'b0;
		go = 1'b0;
		go_op = OP_WORD;
		ld = 1'b0;
		if (wr_evt) begin
			unique case (st_reg)
				C_IDLE: if (!bank_busy || cmd == CMD_ARRAY || cmd == CMD_STATUS
					|| cmd == CMD_SIG || cmd == CMD_CFI) begin // R16 R28
					unique case (cmd)
						CMD_ARRAY: set_mode = 1'b1; // R1
						CMD_STATUS: begin
							set_mode = 1'b1; // R2 R4
							new_mode = MODE_STATUS;
						end
						CMD_SIG: begin
							set_mode = !prot_prog_busy; // R7 R8
							new_mode = MODE_SIG; // R6
						end
						CMD_CFI: begin
							set_mode = 1'b1; // R8
							new_mode = MODE_CFI; // R9
						end
						CMD_CLEAR: clr_flags = 1'b1; // R10
						CMD_ERASE: st_next = C_ERS;
						CMD_PROG, CMD_PROG_ALT: st_next = C_PRG;
						CMD_BUF: if (!(prg_fail_reg && ers_fail_reg)) begin // R25
							set_mode = 1'b1; // R19
							new_mode = MODE_STATUS;
							if (!busy_any)
								st_next = C_BSET;
						end
						default: ; // R24
					endcase
				end
				C_ERS: begin
					st_next = C_IDLE;
					if (cmd == CMD_CONFIRM && !busy_any) begin // R23
						go = 1'b1; // R12
						go_op = OP_ERASE;
						set_mode = 1'b1; // R15
						new_mode = MODE_STATUS;
					end else begin
						set_prg = 1'b1; // R14
						set_ers = 1'b1;
					end
				end
				C_PRG: begin
					st_next = C_IDLE;
					set_mode = 1'b1; // R18
					new_mode = MODE_STATUS;
					if (busy_any)
						set_prg = 1'b1;
					else begin
						go = 1'b1;
						ld = 1'b1;
					end
				end
				C_BSET: if (block_of(wr_addr) == blk_reg && wr_data < DATA_W'(BUF_WORDS))
					st_next = C_BLOAD; // R20
				else begin
					set_prg = 1'b1; // R26
					st_next = C_IDLE;
				end
				C_BLOAD: if (block_of(wr_addr) == blk_reg
					&& off <= ADDR_W'(cnt_reg)) begin // R21
					ld = 1'b1;
					if (left_reg == '0)
						st_next = C_BCONF;
				end else begin
					set_prg = 1'b1; // R26
					st_next = C_IDLE;
				end
				C_BCONF: begin
					st_next = C_IDLE;
					if (cmd == CMD_CONFIRM && block_of(wr_addr) == blk_reg) begin // R23
						go = 1'b1;
						go_op = OP_BUF;
					end else
						set_prg = 1'b1; // R26
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// sequence registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn || hold) begin
			st_reg <= C_IDLE; // R24
			blk_reg <= '0;
			cnt_reg <= '0;
			left_reg <= '0;
			start_reg <= '0;
			first_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			if (st_reg == C_IDLE)
				blk_reg <= block_of(wr_addr);
			if (st_reg == C_BSET) begin
				cnt_reg <= wr_data[BUF_IDX_W-1:0];
				left_reg <= wr_data[BUF_IDX_W-1:0];
				first_reg <= 1'b1;
			end
			if (ld && st_reg == C_BLOAD) begin
				left_reg <= left_reg - 1'b1;
				first_reg <= 1'b0;
				if (first_reg)
					start_reg <= wr_addr;
			end
		end
	end
	// ------------------------------------------------------------
	// engine requests; one bank at a time owns the engine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			op_if.start <= 1'b0;
			op_if.op <= OP_WORD;
			op_if.locked <= 1'b0;
			op_if.base <= '0;
			op_if.last <= '0;
			op_if.load <= 1'b0;
			op_if.load_idx <= '0;
			op_if.load_data <= '0;
			busy_bank_reg <= '0;
			run_op_reg <= OP_WORD;
		end else begin
			op_if.start <= go && !hold;
			op_if.load <= ld && !hold;
			op_if.load_idx <= (st_reg == C_PRG) ? '0 : off[BUF_IDX_W-1:0];
			op_if.load_data <= wr_data;
			if (go) begin
				op_if.op <= go_op;
				op_if.locked <= lock_bits[block_of(wr_addr)]; // R13
				op_if.base <= (go_op == OP_BUF) ? start_reg : wr_addr;
				op_if.last <= (go_op == OP_BUF) ? cnt_reg : '0;
				busy_bank_reg <= wbank; // R27
				run_op_reg <= go_op;
			end
		end
	end
	assign op_if.abort = hold; // R17
	// ------------------------------------------------------------
	// per-bank read modes
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn || hold) begin
			for (int i = 0; i < NUM_BANKS; i++)
				mode_reg[i] <= MODE_ARRAY; // R24
		end else if (set_mode)
			mode_reg[wbank] <= new_mode; // R4 R27
	end
	// ------------------------------------------------------------
	// sticky error flags; a new error wins over a clear
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn || hold) begin
			prg_fail_reg <= 1'b0;
			ers_fail_reg <= 1'b0;
			low_err_reg <= 1'b0;
		end else begin
			prg_fail_reg <= set_prg || (op_if.done && op_if.fail && run_op_reg != OP_ERASE)
				|| (prg_fail_reg && !clr_flags); // R11
			ers_fail_reg <= set_ers || (op_if.done && op_if.fail && run_op_reg == OP_ERASE)
				|| (ers_fail_reg && !clr_flags); // R11
			low_err_reg <= (op_if.done && op_if.fail) || (low_err_reg && !clr_flags);
		end
	end
	// ------------------------------------------------------------
	// read data, latched at the start of each read
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			dq_out <= '0;
			dq_oe <= 1'b0;
			ctrl_busy <= 1'b0;
		end else begin
			dq_oe <= rd_on && !hold;
			ctrl_busy <= busy_any;
			if (rd_evt) begin // R3
				unique case (mode_reg[bank_of(rd_addr)])
					MODE_ARRAY: dq_out <= arr_rdata;
					MODE_STATUS: dq_out <= {8'h00, status};
					MODE_CFI: dq_out <= cfi_word;
					MODE_SIG: unique case (rd_addr[2:0])
						SIG_MAKER: dq_out <= MAKER_ID;
						SIG_DEVICE: dq_out <= PART_ID;
						SIG_LOCK: dq_out <= {15'h0000, lock_bits[block_of(rd_addr)]};
						SIG_CONFIG: dq_out <= cfg_word;
						default: dq_out <= prot_word;
					endcase
				endcase
			end
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic idle_wr;
	assign idle_wr = wr_evt && st_reg == C_IDLE && !hold;
	a_clear_flags: assert property (idle_wr && !bank_busy && cmd == CMD_CLEAR // R10
		&& !op_if.done |=> !prg_fail_reg && !ers_fail_reg && !low_err_reg)
		else $error("clear status left a flag set");
	a_clear_mode_kept: assert property (idle_wr && cmd == CMD_CLEAR // R10
		|=> mode_reg[$past(wbank)] == $past(mode_reg[wbank]))
		else $error("clear status changed read mode");
	a_erase_bad_confirm: assert property (wr_evt && st_reg == C_ERS && !hold // R14
		&& cmd != CMD_CONFIRM |=> prg_fail_reg && ers_fail_reg && st_reg == C_IDLE)
		else $error("bad erase confirm not flagged");
	a_busy_ignore: assert property (idle_wr && bank_busy && cmd == CMD_ERASE // R16
		&& !op_if.done |=> st_reg == C_IDLE && $stable(prg_fail_reg))
		else $error("busy bank accepted erase setup");
	a_status_mode: assert property (idle_wr && cmd == CMD_STATUS // R2
		|=> mode_reg[$past(wbank)] == MODE_STATUS)
		else $error("status command did not set status mode");
	a_array_busy: assert property (idle_wr && bank_busy && cmd == CMD_ARRAY // R1
		|=> mode_reg[$past(wbank)] == MODE_ARRAY && !op_if.abort)
		else $error("read array disturbed busy bank");
	a_buf_reject: assert property (idle_wr && !bank_busy && cmd == CMD_BUF // R25
		&& prg_fail_reg && ers_fail_reg |=> st_reg == C_IDLE)
		else $error("buffer program accepted with both fail flags");
	a_erase_start: assert property (wr_evt && st_reg == C_ERS && !hold // R12 R15
		&& cmd == CMD_CONFIRM && !busy_any |=> op_if.start
		&& mode_reg[$past(wbank)] == MODE_STATUS ##1 op_if.busy)
		else $error("erase confirm did not start engine");
	a_read_latched: assert property (!rd_evt |=> $stable(dq_out)) // R3
		else $error("read data changed without a read edge");
	a_sig_refused: assert property (idle_wr && cmd == CMD_SIG && prot_prog_busy // R7
		|=> mode_reg[$past(wbank)] == $past(mode_reg[wbank]))
		else $error("signature accepted during protection programming");
	a_flag_sticky: assert property (prg_fail_reg && !clr_flags && !hold // R11
		|=> prg_fail_reg)
		else $error("program fail flag dropped by itself");
	a_one_bank: assert property (op_if.busy && !op_if.start |=> $stable(busy_bank_reg)) // R27
		else $error("busy bank changed during operation");
	c_erase_ok: cover property (op_if.done && !op_if.fail && run_op_reg == OP_ERASE);
	c_buf_done: cover property (op_if.done && run_op_reg == OP_BUF);
	c_status_read: cover property (rd_evt && mode_reg[bank_of(rd_addr)] == MODE_STATUS);
	c_locked_fail: cover property (op_if.done && op_if.fail);
endmodule
`default_nettype wire

// >>> verif/fbc_host_model.sv
// host bus model driving the flash strobes, address and data lines
`timescale 1ns/100ps
`default_nettype none
module fbc_host_model
	import fbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic dq_oe,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] dq_in
);
	// bus idle at time zero
	initial begin
		{ce_n, we_n, oe_n} = 3'h7;
		addr = '0;
		dq_in = '0;
	end
	// wait n rising edges, then step just off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// one bus write, strobes low and high four cycles each for the pin syncs
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr = a;
		dq_in = d;
		{ce_n, we_n} = 2'h0;
		tick(4);
		{ce_n, we_n} = 2'h3;
		tick(4);
		addr = ~a; // released lines never keep the old value
		dq_in = ~d;
	endtask
	// single read, enables raised afterwards so the next read relatches
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic oe);
		addr = a;
		{ce_n, oe_n} = 2'h0;
		tick(4);
		d = dq_out;
		oe = dq_oe;
		{ce_n, oe_n} = 2'h3;
		tick(4);
	endtask
endmodule
`default_nettype wire

// >>> verif/fbc_cmd_if_tb_top.sv
// self-checking bench of the flash bank command interpreter
`timescale 1ns/100ps
`default_nettype none
module fbc_cmd_if_tb_top;
	import fbc_pkg::*;
	localparam logic [15:0] MK = 16'h00A5; // arbitrary value
	localparam logic [15:0] PT = 16'h5A01; // arbitrary value
	localparam logic [22:0] B0 = 23'h000000, B1 = 23'h080000, B2 = 23'h100000;
	localparam logic [22:0] B3 = 23'h180000, LK = 23'h030000, BB = 23'h200040;
	logic core_clk, resetn, ce_n, we_n, oe_n, rst_pin_n, arr_we, arr_erase, ctrl_busy, dq_oe;
	logic [22:0] addr, arr_addr, ea, wa;
	logic [15:0] dq_in, dq_out, arr_wdata, wd, d, arr_rd, cfi_w, cfg_w, prot_w;
	logic lockout, prot_busy;
	logic [NUM_BLOCKS-1:0] lock_bits;
	int err_total = 0, samples_checked = 0, cyc = 0, we_cnt = 0, er_cnt = 0;
	fbc_cmd_if #(.ERASE_CYC(200), .MAKER_ID(MK), .PART_ID(PT)) dut (.core_clk(core_clk),
		.resetn(resetn), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.active_low_reset_pin(rst_pin_n), .lockout_pin(lockout), .addr(addr), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .lock_bits(lock_bits), .prot_prog_busy(prot_busy),
		.arr_rdata(arr_rd), .cfi_word(cfi_w), .cfg_word(cfg_w),
		.prot_word(prot_w), .arr_we(arr_we), .arr_erase(arr_erase), .arr_addr(arr_addr),
		.arr_wdata(arr_wdata), .ctrl_busy(ctrl_busy));
	fbc_host_model host (.core_clk(core_clk), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n),
		.we_n(we_n),
		.oe_n(oe_n), .addr(addr), .dq_in(dq_in));
	// clock of 5 ns
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// array pulse monitor and hang limit
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (arr_we === 1'b1) begin
			we_cnt <= we_cnt + 1;
			wd <= arr_wdata;
			wa <= arr_addr;
		end
		if (arr_erase === 1'b1) begin
			er_cnt <= er_cnt + 1;
			ea <= arr_addr;
		end
		if (cyc == 40000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask
	// one read of an address compared with the expected word
	task automatic rs(input logic [22:0] a, input logic [15:0] exp);
		logic oe;
		host.rd(a, d, oe);
		chk("read data", exp, d);
		chk("output enable", 16'h0001, {15'h0, oe});
	endtask
	// bounded wait for the engine to go idle
	task automatic wait_idle();
		host.tick(8);
		for (int i = 0; i < 5000 && ctrl_busy !== 1'b0; i++) host.tick(1);
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		rst_pin_n = 1'b1;
		lock_bits = 128'h108;
		{lockout, prot_busy} = 2'h0;
		{arr_rd, cfi_w, cfg_w, prot_w} = 64'h1234_0051_0C0F_3C3C;
		repeat (6) @(posedge core_clk);
		#1 resetn = 1'b1;
		host.tick(3);
		rs(B3, 16'h1234);
		prot_busy = 1'b1;
		host.wr(B3, CMD_SIG);
		prot_busy = 1'b0;
		rs(B3, 16'h1234);
		host.wr(B0, CMD_STATUS);
		rs(B0, 16'h0080);
		host.wr(B1, CMD_SIG);
		rs(B1, MK);
		rs(B1 + 23'h1, PT);
		rs(B1 + 23'h2, 16'h0001);
		rs(B1 + 23'h3, 16'h3C3C);
		rs(B1 + 23'h5, 16'h0C0F);
		rs(B0, 16'h0080);
		host.wr(B2, CMD_CFI);
		rs(B2, 16'h0051);
		host.wr(B0, CMD_ERASE);
		host.wr(B0, CMD_ARRAY);
		rs(B0, 16'h00B0);
		host.wr(B0, CMD_ARRAY);
		host.wr(B0, CMD_STATUS);
		rs(B0, 16'h00B0);
		host.wr(B0, CMD_ARRAY);
		host.wr(B0, CMD_BUF);
		rs(B0, 16'h1234);
		host.wr(B0, CMD_STATUS);
		host.wr(B0, CMD_CLEAR);
		rs(B0, 16'h0080);
		host.wr(LK, CMD_ERASE);
		host.wr(LK, CMD_CONFIRM);
		wait_idle();
		rs(LK, 16'h00A2);
		host.wr(LK, CMD_CLEAR);
		host.wr(B2, CMD_ERASE);
		host.wr(B2, CMD_CONFIRM);
		rs(B2, 16'h0000);
		host.wr(B2, CMD_CFI);
		rs(B2, 16'h0051);
		host.wr(B2, CMD_ARRAY);
		chk("busy", 16'h0001, {15'h0, ctrl_busy});
		wait_idle();
		chk("erase count", 16'h0001, 16'(er_cnt));
		chk("erase addr", 16'h0010, {9'h0, ea[22:16]});
		host.wr(B3, CMD_PROG);
		host.wr(B3 + 23'h5, 16'hBEEF);
		rs(B3, 16'h0000);
		host.wr(B3, CMD_ERASE);
		host.wr(B3, CMD_CLEAR);
		wait_idle();
		rs(B3, 16'h0080);
		chk("program data", 16'hBEEF, wd);
		chk("program addr", 16'h0005, wa[15:0]);
		host.wr(BB, CMD_BUF);
		rs(BB, 16'h0080);
		host.wr(BB, 16'h0001);
		host.wr(BB, 16'hAAAA);
		host.wr(BB + 23'h1, 16'h5555);
		host.wr(BB, {8'h00, CMD_CONFIRM});
		wait_idle();
		chk("buffer words", 16'h0003, 16'(we_cnt));
		chk("buffer data", 16'h5555, wd);
		chk("buffer addr", 16'h0041, wa[15:0]);
		host.wr(B2, CMD_ERASE);
		host.wr(B2, CMD_CONFIRM);
		host.tick(20);
		rst_pin_n = 1'b0;
		host.tick(6);
		chk("busy", 16'h0000, {15'h0, ctrl_busy});
		rst_pin_n = 1'b1;
		host.tick(220);
		chk("erase count", 16'h0001, 16'(er_cnt));
		rs(B2, 16'h1234);
		host.wr(B2, CMD_STATUS);
		lockout = 1'b1;
		host.tick(6);
		lockout = 1'b0;
		host.tick(6);
		rs(B2, 16'h1234);
		tally_and_finish();
	end
endmodule
`default_nettype wire
